// ---- src/svm_delay.sv ----
`timescale 1ns/1ps
module svm_delay #(
  parameter logic [11:0] CYC = 12'h001
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Trigger and result
  svm_dly_if.dly    d
);
  import svm_pkg::*;

  logic [CNT_W-1:0] cnt_r;    // Cycles elapsed with trig held
  logic [CNT_W-1:0] cnt_nxt;

  // Restart on every drop of trig, saturate at the target count
  always_comb begin
    if (!d.trig) begin
      cnt_nxt = '0;
    end else if (cnt_r < CYC) begin
      cnt_nxt = cnt_r + 1'b1;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // Counter register
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Level outputs, cleared as soon as trig drops
  assign d.done = d.trig && (cnt_r == CYC);
  assign d.busy = d.trig && (cnt_r != CYC);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_dly_restart: assert property (!d.trig |=> cnt_r == '0)
    else $error("delay counter did not restart");
endmodule

// ---- src/svm_dly_if.sv ----
`timescale 1ns/1ps
interface svm_dly_if;
  logic trig;  // Held high while the delay should run
  logic done;  // High once the delay has elapsed with trig held
  logic busy;  // Counting, not yet elapsed
  modport ctl (output trig, input done, input busy);
  modport dly (input trig, output done, output busy);
endinterface

// ---- src/svm_pkg.sv ----
package svm_pkg;
  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h1;
  localparam logic [3:0] OFS_MASK = 4'h2;
  localparam logic [3:0] OFS_SET  = 4'h3;

  // Control register fields
  localparam int CTRL_FLAG_BIT = 5;
  localparam int CTRL_EN_BIT   = 4;
  localparam int SEL_LSB       = 0;
  localparam int SEL_W         = 3;

  // Status and mask fields (same layout)
  localparam int STAT_LV_BIT     = 0;
  localparam int STAT_SETTLE_BIT = 1;
  localparam int STAT_W          = 2;

  // Reset values
  localparam logic [7:0]        CTRL_RST = 8'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 2'h0;

  // Threshold table in millivolts, code 000 lowest to 111 highest
  localparam int MV_W = 13;
  localparam logic [MV_W-1:0] THR_MV [8] = '{13'h07d0, 13'h0898, 13'h0960, 13'h0a8c,
                                             13'h0bb8, 13'h0ce4, 13'h0e10, 13'h1130};

  // Timing: clock period, delays in ns, counts rounded up to whole cycles
  localparam int CLK_NS    = 40;
  localparam int SETTLE_NS = 100000;
  localparam int IRQ_NS    = 60000;
  localparam int CNT_W     = 12;
  localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] IRQ_CYC    = CNT_W'((IRQ_NS + CLK_NS - 1) / CLK_NS);
endpackage

// ---- src/svm_top.sv ----
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Threshold selectable from 2.0V to 4.4V
// - Flag high while supply below threshold
// - Reference on automatically with detector enable
// - Detector keeps running during sleep or idle
// - Request raised only after fixed delay
// - Request via shared interrupt; flag also pollable
// - Low supply in power-down sets request
// - Request setting wakes from sleep or idle
// - Control: flag bit5, enable bit4, select 2..0
// - Eight select codes map to ascending thresholds
// - Request never cleared automatically on service
// - Wake on request rise, ignoring enables
module svm_top (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  // Register port
  input  wire logic [svm_pkg::ADDR_W-1:0] addr,
  input  wire logic [svm_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [svm_pkg::DATA_W-1:0] rdata,
  // Analogue comparator side
  input  wire logic                       cmp_below,
  output logic                            detector_power,
  output logic                            ref_enable,
  output logic      [svm_pkg::SEL_W-1:0]  threshold_select,
  output logic      [svm_pkg::MV_W-1:0]   threshold_mv,
  // Core side
  input  wire logic                       sleep_mode,
  output logic                            low_voltage_flag_out,
  output logic                            lv_irq_request,
  output logic                            irq,
  output logic                            wake_req
);
  import svm_pkg::*;

  // Control state
  logic              en_r, en_nxt;         // Detector enable
  logic [SEL_W-1:0]  sel_r, sel_nxt;       // Threshold code
  logic              flag_r, flag_nxt;     // Low-voltage flag
  logic              cmp_s1_r, cmp_s2_r;   // Comparator synchroniser
  // Interrupt state
  logic [STAT_W-1:0] st_r, st_nxt;         // Sticky status
  logic [STAT_W-1:0] mask_r, mask_nxt;     // Interrupt mask
  logic              lv_done_d_r;          // Last request-delay result
  logic              st_done_d_r;          // Last settle-delay result
  logic              wake_r, wake_nxt;     // Wake pulse
  logic [DATA_W-1:0] rdata_r, rdata_nxt;   // Read data, one cycle late
  // Decoded strobes and events
  logic              wr_ctrl, wr_stat, wr_mask, wr_set;
  logic              lv_evt, settle_evt;
  logic [STAT_W-1:0] evt, clr, swset;
  logic [DATA_W-1:0] ctrl_view;

  svm_dly_if settle_if ();
  svm_dly_if irqd_if ();

  // Stabilisation timer runs whenever the detector is on
  svm_delay #(.CYC(SETTLE_CYC)) u_settle (
    .mclk (mclk),
    .nrst (nrst),
    .d    (settle_if.dly)
  );

  // Request delay timer restarts on every flag drop, so a hovering supply
  // only raises the request once the flag has stayed high the whole delay
  svm_delay #(.CYC(IRQ_CYC)) u_irqd (
    .mclk (mclk),
    .nrst (nrst),
    .d    (irqd_if.dly)
  );

  assign settle_if.trig = en_r;
  assign irqd_if.trig   = flag_r;

  // Strobe decode
  assign wr_ctrl = wr && (addr == OFS_CTRL);
  assign wr_stat = wr && (addr == OFS_STAT);
  assign wr_mask = wr && (addr == OFS_MASK);
  assign wr_set  = wr && (addr == OFS_SET);

  // Comparator comes from the analogue domain: two flops before use
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
    end else begin
      cmp_s1_r <= cmp_below;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  // Control next values; sleep_mode is deliberately not used here
  always_comb begin
    en_nxt  = en_r;
    sel_nxt = sel_r;
    if (wr_ctrl) begin
      en_nxt  = wdata[CTRL_EN_BIT];
      sel_nxt = wdata[SEL_LSB +: SEL_W];
    end
    // Flag follows the comparator only while enabled
    flag_nxt = en_r && cmp_s2_r;
  end

  // Control registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      en_r   <= CTRL_RST[CTRL_EN_BIT];
      sel_r  <= CTRL_RST[SEL_LSB +: SEL_W];
      flag_r <= CTRL_RST[CTRL_FLAG_BIT];
    end else begin
      en_r   <= en_nxt;
      sel_r  <= sel_nxt;
      flag_r <= flag_nxt;
    end
  end

  // Analogue controls: the reference needs no separate enable bit
  assign detector_power       = en_r;
  assign ref_enable           = en_r;
  assign threshold_select     = sel_r;
  assign threshold_mv         = THR_MV[sel_r];
  assign low_voltage_flag_out = flag_r;

  // One-cycle events from the rising edge of each elapsed delay
  assign lv_evt     = irqd_if.done && !lv_done_d_r;
  assign settle_evt = settle_if.done && !st_done_d_r;

  always_comb begin
    evt                  = '0;
    evt[STAT_LV_BIT]     = lv_evt;
    evt[STAT_SETTLE_BIT] = settle_evt;
    clr   = wr_stat ? wdata[STAT_W-1:0] : '0;
    swset = wr_set  ? wdata[STAT_W-1:0] : '0;
    // Set wins over a same-cycle clear; nothing clears on service
    st_nxt   = (st_r & ~clr) | evt | swset;
    mask_nxt = wr_mask ? wdata[STAT_W-1:0] : mask_r;
    // Wake on a low-to-high of the request while sleep_mode is high, mask not consulted
    wake_nxt = sleep_mode && st_nxt[STAT_LV_BIT] && !st_r[STAT_LV_BIT];
  end

  // Interrupt registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_r        <= STAT_RST;
      mask_r      <= MASK_RST;
      lv_done_d_r <= 1'b0;
      st_done_d_r <= 1'b0;
      wake_r      <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      mask_r      <= mask_nxt;
      lv_done_d_r <= irqd_if.done;
      st_done_d_r <= settle_if.done;
      wake_r      <= wake_nxt;
    end
  end

  // Shared level interrupt: every unmasked sticky bit feeds one line
  assign irq            = |(st_r & mask_r);
  assign lv_irq_request = st_r[STAT_LV_BIT];
  assign wake_req       = wake_r;

  // Read mux; unmapped offsets and unused bits read zero
  always_comb begin
    ctrl_view                        = '0;
    ctrl_view[CTRL_FLAG_BIT]         = flag_r;
    ctrl_view[CTRL_EN_BIT]           = en_r;
    ctrl_view[SEL_LSB +: SEL_W]      = sel_r;
    rdata_nxt = '0;
    if (rd) begin
      unique case (addr)
        OFS_CTRL: rdata_nxt = ctrl_view;
        OFS_STAT: rdata_nxt = {{(DATA_W-STAT_W){1'b0}}, st_r};
        OFS_MASK: rdata_nxt = {{(DATA_W-STAT_W){1'b0}}, mask_r};
        default:  rdata_nxt = '0;
      endcase
    end
  end

  // Read data register, valid only the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  // Helper: consecutive cycles with the flag high, saturating
  logic [CNT_W-1:0] hi_cnt_r;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hi_cnt_r <= '0;
    end else if (!flag_r) begin
      hi_cnt_r <= '0;
    end else if (hi_cnt_r != {CNT_W{1'b1}}) begin
      hi_cnt_r <= hi_cnt_r + 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_ctrl_wr;
    wr && (addr == OFS_CTRL);
  endsequence

  sequence s_lv_kept;
    st_r[STAT_LV_BIT] && !(wr && addr == OFS_STAT && wdata[STAT_LV_BIT]);
  endsequence

  a_flag_follow: assert property (en_r && cmp_s2_r |=> flag_r)
    else $error("flag not raised on low supply");
  a_flag_off: assert property (!en_r || !cmp_s2_r |=> !flag_r)
    else $error("flag high without low supply");
  a_ref_auto: assert property (s_ctrl_wr |=> ref_enable == $past(wdata[CTRL_EN_BIT]))
    else $error("reference not following enable write");
  a_thr_sel: assert property (s_ctrl_wr |=> threshold_select == $past(wdata[2:0]))
    else $error("threshold code not stored");
  a_sleep_keep: assert property (en_r && sleep_mode && !wr |=> detector_power)
    else $error("detector dropped in sleep");
  a_irq_delay: assert property (lv_evt |-> hi_cnt_r == IRQ_CYC)
    else $error("request raised at wrong delay");
  a_lv_set: assert property (lv_evt |=> st_r[STAT_LV_BIT])
    else $error("request flag not set");
  a_no_autoclr: assert property (s_lv_kept |=> st_r[STAT_LV_BIT])
    else $error("request flag cleared without software");
  a_wake_rise: assert property ($rose(st_r[STAT_LV_BIT]) && $past(sleep_mode) |-> wake_req)
    else $error("no wake on request rise");
  a_read_ctrl: assert property (rd && addr == OFS_CTRL |=>
      rdata == {2'b00, $past(flag_r), $past(en_r), 1'b0, $past(sel_r)})
    else $error("control readback wrong");
endmodule

// ---- testbench/svm_core_model.sv ----
`timescale 1ns/1ps
// Stand-in for the analogue comparator and the core's wake logic
module svm_core_model (
  // Clock
  input  wire logic                     mclk,
  // Analogue side
  input  wire logic [svm_pkg::MV_W-1:0] supply_mv,
  input  wire logic [svm_pkg::MV_W-1:0] threshold_mv,
  input  wire logic                     detector_power,
  output logic                          cmp_below,
  // Core side
  input  wire logic                     wake_req,
  output int                            wake_cnt
);
  initial cmp_below = 1'b0;
  initial wake_cnt = 0;
  // Unpowered comparator chatters, so a design that ignores enable shows it
  always @(posedge mclk) begin
    if (detector_power === 1'b1) begin
      cmp_below <= (supply_mv < threshold_mv);
    end else begin
      cmp_below <= (cmp_below === 1'b1) ? 1'b0 : 1'b1;
    end
  end
  // Core counts each one-cycle wake pulse; toggling flags are tolerated
  always @(posedge mclk) begin
    if (wake_req === 1'b1) begin
      wake_cnt <= wake_cnt + 1;
    end
  end
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import svm_pkg::*;
  // Bench signals
  logic              mclk, nrst, wr, rd, sleep_mode, cmp_below, dpow, refe, flag, req, irq, wake;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, v;
  logic [SEL_W-1:0]  tsel;
  logic [MV_W-1:0]   thr, supply;
  int                wake_cnt, n, n_fail, n_tests;
  // Expected thresholds, lowest code first
  logic [MV_W-1:0]   exp_mv [8] = '{13'h07d0, 13'h0898, 13'h0960, 13'h0a8c,
                                    13'h0bb8, 13'h0ce4, 13'h0e10, 13'h1130};

  svm_top uut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cmp_below(cmp_below), .detector_power(dpow), .ref_enable(refe),
    .threshold_select(tsel), .threshold_mv(thr), .sleep_mode(sleep_mode),
    .low_voltage_flag_out(flag), .lv_irq_request(req), .irq(irq), .wake_req(wake));
  svm_core_model core (.mclk(mclk), .supply_mv(supply), .threshold_mv(thr),
    .detector_power(dpow), .cmp_below(cmp_below), .wake_req(wake), .wake_cnt(wake_cnt));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Compare one value
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle write; effect lands at the taking edge
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  // One-cycle read; data stands only in the following cycle
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Bounded wait for flag (0) or request (1) to reach a level
  task automatic wait_for(input int s, input logic lvl, input int lim, output int k);
    k = 0;
    while (((s == 0) ? flag : req) !== lvl && k < lim) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (((s == 0) ? flag : req) !== lvl) begin
      n_fail++;
      $display("unexpected timeout waiting on signal %0d", s);
      give_verdict();
    end
  endtask

  // Single closing point
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {nrst, wr, rd, sleep_mode, addr, wdata} = '0;
    supply = 13'h1388;
    n_fail = 0;
    n_tests = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    // Every offset reads zero after reset, unmapped ones included
    for (int i = 0; i < 16; i++) begin
      rd_reg(ADDR_W'(i), v);
      chk("reset_read", v, 16'h0000);
    end
    $display("test reset done");
    // Read-only and unimplemented bits ignore writes
    wr_reg(OFS_CTRL, 8'hff);
    // Give the synchroniser time to drain chatter from the unpowered comparator
    repeat (6) @(posedge mclk);
    rd_reg(OFS_CTRL, v);
    chk("ctrl_fields", v, 16'h0017);
    chk("ref_enable", refe, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      wr_reg(OFS_CTRL, 8'h10 | 8'(i));
      chk("threshold_mv", thr, exp_mv[i]);
      chk("threshold_select", tsel, 16'(i));
    end
    $display("test fields done");
    // Flag trusted only once settling has finished
    wr_reg(OFS_CTRL, 8'h15);
    repeat (SETTLE_CYC + 10) @(posedge mclk);
    rd_reg(OFS_STAT, v);
    chk("settle_status", v, 16'h0002);
    supply <= 13'h0bb8;
    wait_for(0, 1'b1, 10, n);
    rd_reg(OFS_CTRL, v);
    chk("ctrl_flag", v, 16'h0035);
    wait_for(1, 1'b1, 2000, n);
    chk("irq_delay", 16'(n), 16'(IRQ_CYC) - 16'h0001);
    chk("irq_masked", irq, 16'h0000);
    wr_reg(OFS_MASK, 8'h01);
    chk("irq_unmasked", irq, 16'h0001);
    repeat (50) @(posedge mclk);
    rd_reg(OFS_STAT, v);
    chk("sticky_status", v, 16'h0003);
    wr_reg(OFS_STAT, 8'h01);
    chk("irq_cleared", irq, 16'h0000);
    $display("test request done");
    // Sleeping core woken by a fresh request, mask closed
    wr_reg(OFS_MASK, 8'h00);
    supply <= 13'h0d48;
    wait_for(0, 1'b0, 10, n);
    sleep_mode <= 1'b1;
    supply <= 13'h0bb8;
    wait_for(1, 1'b1, 2000, n);
    repeat (2) @(posedge mclk);
    chk("wake_count", 16'(wake_cnt), 16'h0001);
    // Preset request blocks the next wake
    sleep_mode <= 1'b0;
    wr_reg(OFS_STAT, 8'h01);
    supply <= 13'h0d48;
    wait_for(0, 1'b0, 10, n);
    wr_reg(OFS_SET, 8'h01);
    sleep_mode <= 1'b1;
    supply <= 13'h0bb8;
    repeat (IRQ_CYC + 100) @(posedge mclk);
    chk("wake_blocked", 16'(wake_cnt), 16'h0001);
    $display("test wake done");
    // Disabled detector ignores a chattering comparator
    wr_reg(OFS_CTRL, 8'h05);
    repeat (20) @(posedge mclk);
    chk("flag_disabled", flag, 16'h0000);
    chk("power_off", dpow, 16'h0000);
    $display("test disable done");
    give_verdict();
  end
endmodule
